// ===== include/bfsc_pkg.sv
// Package: constants and types for the boost clock spread and fault flag block
package bfsc_pkg;

    // Timing
    localparam int CLK_PERIOD_NS   = 20;
    localparam int OFF_TIME_NS     = 50;
    localparam int OFF_CYC_INT     = (OFF_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SPREAD_HOLD_CYC = 32;
    localparam int SPREAD_UPD_CYC  = 32;

    // Widths
    localparam int FREQ_W  = 12;
    localparam int CNT_W   = 14;
    localparam int OFS_W   = 5;
    localparam int QUIET_W = 6;
    localparam int CMP_N   = 5;
    localparam int INT_N   = 4;

    localparam logic [CNT_W-1:0]   OFF_CYC   = CNT_W'(OFF_CYC_INT);
    localparam logic [QUIET_W-1:0] HOLD_LIM  = QUIET_W'(SPREAD_HOLD_CYC + 1);
    localparam logic [OFS_W-1:0]   UPD_LAST  = OFS_W'(SPREAD_UPD_CYC - 1);

    // Comparator vector positions
    localparam int CMP_FB_NEAR    = 0;
    localparam int CMP_FB_RELEASE = 1;
    localparam int CMP_FB_OV      = 2;
    localparam int CMP_FB_OV_REL  = 3;
    localparam int CMP_IOUT_LOW   = 4;

    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_STATUS   = 8'h04;
    localparam logic [7:0] ADDR_INT_STAT = 8'h08;
    localparam logic [7:0] ADDR_INT_MASK = 8'h0c;

    // Field positions and reset values
    localparam int STAT_OFS_LSB = 8;
    localparam int INT_OL_SET   = 0;
    localparam int INT_OV_SET   = 1;
    localparam int INT_OV_CLR   = 2;
    localparam int INT_MODE     = 3;
    localparam logic             CTRL_RST     = 1'b1;
    localparam logic [INT_N-1:0] INT_MASK_RST = 4'h0;
    localparam logic [OFS_W-1:0] LFSR_SEED    = 5'h01;

    typedef enum logic [2:0] {
        MODE_FIXED  = 3'b001,
        MODE_SPREAD = 3'b010,
        MODE_EXT    = 3'b100
    } bfsc_mode_type;

    typedef struct packed {
        bfsc_mode_type       mode;
        logic                pin_q;
        logic [QUIET_W-1:0]  quiet;
        logic [OFS_W-1:0]    lfsr;
        logic [OFS_W-1:0]    offset;
        logic [OFS_W-1:0]    upd;
        logic [CNT_W-1:0]    cnt;
        logic                in_off;
        logic                ol_flag;
        logic                ov;
        logic                sw_drive;
        logic                tg;
        logic                sw_en;
        logic [INT_N-1:0]    int_stat;
        logic [INT_N-1:0]    int_mask;
        logic                irq;
        logic [31:0]         prdata;
        logic                pready;
        logic                pslverr;
    } bfsc_state_type;

endpackage : bfsc_pkg

// ===== include/bfsc_cmp_if.sv
// Interface: synchronised comparator results between synchroniser and control
`timescale 1ns/10ps
`default_nettype none
interface bfsc_cmp_if;
    logic [bfsc_pkg::CMP_N-1:0] cmp;
    modport src (output cmp);
    modport dst (input cmp);
endinterface : bfsc_cmp_if
`default_nettype wire

// ===== rtl/bfsc_sync.sv
// Two-stage synchroniser for the analog comparator results
`timescale 1ns/10ps
`default_nettype none
module bfsc_sync #(
    parameter int N = bfsc_pkg::CMP_N
) (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         rstn,
    // Raw comparator levels
    input  wire logic [N-1:0] raw,
    // Synchronised levels
    bfsc_cmp_if.src           cmp_if
);

    logic [N-1:0] meta_r;
    logic [N-1:0] sync_r;

    // Stage one feeds only stage two
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_bit
            always_ff @(posedge mclk or negedge rstn) begin
                if (!rstn) begin
                    meta_r[i] <= 1'b0;
                    sync_r[i] <= 1'b0;
                end else begin
                    meta_r[i] <= raw[i];
                    sync_r[i] <= meta_r[i];
                end
            end
        end
    endgenerate

    assign cmp_if.cmp = sync_r;

endmodule : bfsc_sync
`default_nettype wire

// ===== rtl/bfsc_top.sv
// Switching clock source, spread spectrum and feedback fault flags
//
// Summary of operation
// - Mode pin: low fixed, high spread, toggling external
// - Spread enabled after pin high over 32 switching cycles
// - Spread frequency nominal up to plus 31 percent
// - Offset refreshed every 32 switching cycles
// - External clock taken only near soft-start end
// - Period is fixed off (50 ns rounded up to 3 cycles, 60 ns) then variable
// - Open-load flag: feedback near and current low
// - Open-load flag held until feedback release threshold
// - Overvoltage stops switching, raises disconnect gate
// - Switching resumes after feedback falls by hysteresis
// - Overvoltage never touches the open-load flag
// - Open-load pin only pulls low, needs pull-up
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module bfsc_top #(
    parameter int FREQ_W = bfsc_pkg::FREQ_W
) (
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              rstn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output var  logic [31:0]       prdata,
    output var  logic              pready,
    output var  logic              pslverr,
    // Clock source and frequency setting
    input  wire logic              clock_mode_pin,
    input  wire logic [FREQ_W-1:0] freq_set_input,
    input  wire logic              ss_near_done,
    // Raw comparator results
    input  wire logic              cmp_fb_near,
    input  wire logic              cmp_fb_release,
    input  wire logic              cmp_fb_ov,
    input  wire logic              cmp_fb_ov_release,
    input  wire logic              cmp_iout_low,
    // Power stage and flags
    output var  logic              power_switch_node,
    output var  logic              load_disconnect_gate,
    output var  logic              open_load_flag_out,
    output var  logic              open_load_flag_oe,
    output var  logic              irq
);

    localparam int CW = bfsc_pkg::CNT_W;
    localparam int OW = bfsc_pkg::OFS_W;
    localparam int PW = FREQ_W + OW + 3;
    localparam logic [bfsc_pkg::QUIET_W-1:0] QUIET_W_ONE = bfsc_pkg::QUIET_W'(1);

    bfsc_pkg::bfsc_state_type st_r;
    bfsc_pkg::bfsc_state_type st_nxt;

    bfsc_cmp_if cmp_bus ();

    bfsc_sync #(
        .N      (bfsc_pkg::CMP_N)
    ) u_sync (
        .mclk   (mclk),
        .rstn   (rstn),
        .raw    ({cmp_iout_low, cmp_fb_ov_release, cmp_fb_ov,
                  cmp_fb_release, cmp_fb_near}),
        .cmp_if (cmp_bus)
    );

    // Combinational helpers
    logic          pin_edge;
    logic          pin_rise;
    logic          ext_locked;
    logic [PW-1:0] prod;
    logic [PW-1:0] shrink;
    logic [CW-1:0] var_cyc;
    logic          tick;
    logic          lfsr_fb;
    logic          apb_wr;
    logic          apb_setup;
    logic          addr_ok;
    logic [bfsc_pkg::INT_N-1:0] ev;
    logic          fb_near;
    logic          fb_rel;
    logic          fb_ov;
    logic          fb_ovrel;
    logic          iout_low;

    always_comb begin
        st_nxt   = st_r;
        fb_near  = cmp_bus.cmp[bfsc_pkg::CMP_FB_NEAR];
        fb_rel   = cmp_bus.cmp[bfsc_pkg::CMP_FB_RELEASE];
        fb_ov    = cmp_bus.cmp[bfsc_pkg::CMP_FB_OV];
        fb_ovrel = cmp_bus.cmp[bfsc_pkg::CMP_FB_OV_REL];
        iout_low = cmp_bus.cmp[bfsc_pkg::CMP_IOUT_LOW];
        ev       = '0;

        // Mode pin is synchronous; any change counts as a clock edge
        st_nxt.pin_q = clock_mode_pin;
        pin_edge     = clock_mode_pin ^ st_r.pin_q;
        pin_rise     = clock_mode_pin & ~st_r.pin_q;
        ext_locked   = (st_r.mode == bfsc_pkg::MODE_EXT) && ss_near_done;

        // Steps once per offset update in every mode: a per-clock step would revisit one
        // state at each update, as 32 equal periods span a multiple of its 32 states.
        // The zero-run term adds the all-zero state
        lfsr_fb     = st_r.lfsr[4] ^ st_r.lfsr[2] ^ (st_r.lfsr[3:0] == 4'h0);

        // Period shrink of about offset percent; only the external-mode foldback below runs longer than nominal
        prod   = PW'(freq_set_input) * PW'(st_r.offset);
        shrink = ((prod << 2) + prod) >> 9;
        if (st_r.mode == bfsc_pkg::MODE_SPREAD) begin
            var_cyc = CW'(freq_set_input) - CW'(shrink);
        end else if ((st_r.mode == bfsc_pkg::MODE_EXT) && !ss_near_done) begin
            // Foldback: start on a halved internal rate until soft-start is nearly done
            var_cyc = CW'({freq_set_input, 1'b0});
        end else begin
            var_cyc = CW'(freq_set_input);
        end
        if (var_cyc == '0) begin
            var_cyc = CW'(1);
        end

        // Switching period: fixed off interval, then variable interval
        tick = 1'b0;
        if (st_r.in_off) begin
            if (st_r.cnt == '0) begin
                st_nxt.in_off = 1'b0;
                st_nxt.cnt    = var_cyc - CW'(1);
            end else begin
                st_nxt.cnt = st_r.cnt - CW'(1);
            end
        end else begin
            // Internal count still ends a period if the external clock stalls
            if ((ext_locked && pin_rise) || (st_r.cnt == '0)) begin
                tick          = 1'b1;
                st_nxt.in_off = 1'b1;
                st_nxt.cnt    = bfsc_pkg::OFF_CYC - CW'(1);
            end else begin
                st_nxt.cnt = st_r.cnt - CW'(1);
            end
        end

        // Mode decode counted in switching periods (ticks) since the last pin edge
        if (pin_edge) begin
            st_nxt.quiet = '0;
            if (st_r.mode != bfsc_pkg::MODE_EXT) begin
                st_nxt.mode      = bfsc_pkg::MODE_EXT;
                ev[bfsc_pkg::INT_MODE] = 1'b1;
            end
        end else if (tick && (st_r.quiet != bfsc_pkg::HOLD_LIM)) begin
            st_nxt.quiet = st_r.quiet + QUIET_W_ONE;
        end
        if (!pin_edge && (st_r.quiet == bfsc_pkg::HOLD_LIM)) begin
            if (clock_mode_pin && (st_r.mode != bfsc_pkg::MODE_SPREAD)) begin
                st_nxt.mode = bfsc_pkg::MODE_SPREAD;
                ev[bfsc_pkg::INT_MODE] = 1'b1;
            end else if (!clock_mode_pin && (st_r.mode != bfsc_pkg::MODE_FIXED)) begin
                st_nxt.mode = bfsc_pkg::MODE_FIXED;
                ev[bfsc_pkg::INT_MODE] = 1'b1;
            end
        end

        // Offset update once per 32 switching periods
        if (tick) begin
            st_nxt.upd = st_r.upd + OW'(1);
            if (st_r.upd == bfsc_pkg::UPD_LAST) begin
                st_nxt.offset = (st_r.mode == bfsc_pkg::MODE_SPREAD) ? st_r.lfsr : '0;
                st_nxt.lfsr   = {st_r.lfsr[3:0], lfsr_fb};
            end
        end
        if (st_r.mode != bfsc_pkg::MODE_SPREAD) begin
            st_nxt.offset = '0;
        end

        // Open-load flag with hysteresis, independent of overvoltage
        if (!st_r.ol_flag && fb_near && iout_low) begin
            st_nxt.ol_flag = 1'b1;
            ev[bfsc_pkg::INT_OL_SET] = 1'b1;
        end else if (st_r.ol_flag && fb_rel) begin
            st_nxt.ol_flag = 1'b0;
        end

        // Overvoltage latch with its own release comparator
        if (!st_r.ov && fb_ov) begin
            st_nxt.ov = 1'b1;
            ev[bfsc_pkg::INT_OV_SET] = 1'b1;
        end else if (st_r.ov && fb_ovrel) begin
            st_nxt.ov = 1'b0;
            ev[bfsc_pkg::INT_OV_CLR] = 1'b1;
        end

        st_nxt.sw_drive = ~st_nxt.in_off & ~st_nxt.ov & st_r.sw_en;
        st_nxt.tg       = st_nxt.ov | ~st_r.sw_en;

        // APB: answer registered in setup, completes in first access cycle
        apb_setup = psel & ~penable;
        apb_wr    = psel & penable & pwrite & st_r.pready;
        addr_ok   = (paddr == bfsc_pkg::ADDR_CTRL) || (paddr == bfsc_pkg::ADDR_STATUS) ||
                    (paddr == bfsc_pkg::ADDR_INT_STAT) || (paddr == bfsc_pkg::ADDR_INT_MASK);
        st_nxt.pready  = apb_setup;
        st_nxt.pslverr = apb_setup & ~addr_ok;
        if (apb_setup && !pwrite) begin
            case (paddr)
                bfsc_pkg::ADDR_CTRL: begin
                    st_nxt.prdata = {31'h0, st_r.sw_en};
                end
                bfsc_pkg::ADDR_STATUS: begin
                    st_nxt.prdata = {19'h0, st_r.offset, 3'h0, st_r.ov, st_r.ol_flag,
                                     st_r.mode};
                end
                bfsc_pkg::ADDR_INT_STAT: begin
                    st_nxt.prdata = {28'h0, st_r.int_stat};
                end
                bfsc_pkg::ADDR_INT_MASK: begin
                    st_nxt.prdata = {28'h0, st_r.int_mask};
                end
                default: begin
                    st_nxt.prdata = 32'h0;
                end
            endcase
        end
        if (apb_wr && (paddr == bfsc_pkg::ADDR_CTRL)) begin
            st_nxt.sw_en = pwdata[0];
        end
        if (apb_wr && (paddr == bfsc_pkg::ADDR_INT_MASK)) begin
            st_nxt.int_mask = pwdata[bfsc_pkg::INT_N-1:0];
        end

        // Sticky status: write one clears, a new event wins over the clear
        if (apb_wr && (paddr == bfsc_pkg::ADDR_INT_STAT)) begin
            st_nxt.int_stat = st_r.int_stat & ~pwdata[bfsc_pkg::INT_N-1:0];
        end
        st_nxt.int_stat = st_nxt.int_stat | ev;
        st_nxt.irq      = |(st_nxt.int_stat & st_nxt.int_mask);
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st_r          <= '0;
            st_r.mode     <= bfsc_pkg::MODE_FIXED;
            st_r.lfsr     <= bfsc_pkg::LFSR_SEED;
            st_r.in_off   <= 1'b1;
            st_r.cnt      <= bfsc_pkg::OFF_CYC - bfsc_pkg::CNT_W'(1);
            st_r.sw_en    <= bfsc_pkg::CTRL_RST;
            st_r.int_mask <= bfsc_pkg::INT_MASK_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register
    assign prdata               = st_r.prdata;
    assign pready               = st_r.pready;
    assign pslverr              = st_r.pslverr;
    assign power_switch_node    = st_r.sw_drive;
    assign load_disconnect_gate = st_r.tg;
    // Open-drain: data is held low, only the enable follows the flag
    assign open_load_flag_out   = 1'b0;
    assign open_load_flag_oe    = st_r.ol_flag;
    assign irq                  = st_r.irq;

endmodule : bfsc_top
`default_nettype wire

// ===== verif/bfsc_chk.sv
// Checker: port-level timing properties of the clock and fault flag block
`timescale 1ns/10ps
`default_nettype none
module bfsc_chk (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Raw comparator levels
    input wire logic cmp_fb_near,
    input wire logic cmp_fb_release,
    input wire logic cmp_fb_ov,
    input wire logic cmp_fb_ov_release,
    input wire logic cmp_iout_low,
    // Power stage and flag
    input wire logic power_switch_node,
    input wire logic load_disconnect_gate,
    input wire logic open_load_flag_out,
    input wire logic open_load_flag_oe
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    sequence off_gap;
        !power_switch_node [*2];
    endsequence
    sequence ov_seen;
        $rose(cmp_fb_ov) ##1 cmp_fb_ov;
    endsequence
    // Without either feedback comparator the flag has no cause to move
    sequence fb_quiet;
        (!cmp_fb_near && !cmp_fb_release) [*5];
    endsequence

    ov_stop_a: assert property (
        ov_seen |-> ##[0:3] (load_disconnect_gate && !power_switch_node))
        else $error("switching not stopped after overvoltage");
    gate_quiet_a: assert property (
        load_disconnect_gate |-> !power_switch_node)
        else $error("switch on while load isolated");
    off_time_a: assert property (
        $fell(power_switch_node) |=> off_gap)
        else $error("off interval shorter than three cycles");
    flag_set_a: assert property (
        $rose(open_load_flag_oe) |-> $past(cmp_fb_near, 3) && $past(cmp_iout_low, 3))
        else $error("open-load flag set without both conditions");
    flag_rel_a: assert property (
        $fell(open_load_flag_oe) |-> $past(cmp_fb_release, 3))
        else $error("open-load flag released early");
    flag_hold_a: assert property (
        fb_quiet |-> $stable(open_load_flag_oe))
        else $error("open-load flag moved without its comparators");
    drain_only_a: assert property (
        !open_load_flag_out)
        else $error("open-load pin driven high");
    ov_recover_a: assert property (
        $fell(load_disconnect_gate) |-> $past(cmp_fb_ov_release, 3))
        else $error("switching resumed before feedback fell");
endmodule : bfsc_chk
`default_nettype wire

// ===== verif/bfsc_far.sv
// Far-side model: feedback comparators, flag pull-up, external sync clock
`timescale 1ns/10ps
`default_nettype none
module bfsc_far (
    // Clock
    input  wire logic mclk,
    // Bench commands
    input  wire logic ext_en,
    input  wire logic pin_lvl,
    input  var  int   fb_mv,
    input  wire logic iout_lo,
    // Towards the block
    output var  logic clock_mode_pin,
    output var  logic cmp_fb_near,
    output var  logic cmp_fb_release,
    output var  logic cmp_fb_ov,
    output var  logic cmp_fb_ov_release,
    output var  logic cmp_iout_low,
    // Open-drain flag
    input  wire logic flag_out,
    input  wire logic flag_oe,
    output var  logic flag_pin
);
    logic [1:0] div_r = 2'h0;
    logic       tgl_r = 1'b0;

    always_ff @(posedge mclk) begin
        div_r <= div_r + 2'h1;
        if (div_r == 2'h3) begin
            tgl_r <= ~tgl_r;
        end
    end
    // Sync source runs freely but reaches the pin only while selected; otherwise the pin sits at its tie level
    assign clock_mode_pin    = ext_en ? tgl_r : pin_lvl;
    // Feedback is given in mV from the regulation point
    assign cmp_fb_near       = fb_mv >= -45;
    assign cmp_fb_release    = fb_mv <= -65;
    assign cmp_fb_ov         = fb_mv >= 30;
    assign cmp_fb_ov_release = fb_mv <= 15;
    assign cmp_iout_low      = iout_lo;
    assign flag_pin          = (flag_oe && !flag_out) ? 1'b0 : 1'b1;
endmodule : bfsc_far
`default_nettype wire

// ===== verif/testbench.sv
// Top-level bench: APB access, clock mode, spread and fault flag tests
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, x) begin total_checks++; if ((g) !== (x)) begin failures++; \
    $display("Error %0t got %h exp %h", $time, (g), (x)); end end
module testbench;
    logic        mclk, rstn, psel, penable, pwrite, pready, pslverr, e, ia, psn_q;
    logic        ss_near_done, ext_en, pin_lvl, iout_lo, cm_pin, c_near, c_rel, c_ov;
    logic        c_ovr, c_il, psn, gate, fl_out, fl_oe, fl_pin, irq;
    logic [7:0]  paddr;
    logic [11:0] fsi;
    logic [31:0] pwdata, prdata, d;
    int          fb_mv, f0, prev, k, on_c, per_c;
    int          failures = 0, total_checks = 0, falls = 0;

    bfsc_top uut (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .clock_mode_pin(cm_pin), .freq_set_input(fsi), .ss_near_done(ss_near_done),
        .cmp_fb_near(c_near), .cmp_fb_release(c_rel), .cmp_fb_ov(c_ov),
        .cmp_fb_ov_release(c_ovr), .cmp_iout_low(c_il), .power_switch_node(psn),
        .load_disconnect_gate(gate), .open_load_flag_out(fl_out),
        .open_load_flag_oe(fl_oe), .irq(irq));
    bfsc_far far (.mclk(mclk), .ext_en(ext_en), .pin_lvl(pin_lvl), .fb_mv(fb_mv),
        .iout_lo(iout_lo), .clock_mode_pin(cm_pin), .cmp_fb_near(c_near),
        .cmp_fb_release(c_rel), .cmp_fb_ov(c_ov), .cmp_fb_ov_release(c_ovr),
        .cmp_iout_low(c_il), .flag_out(fl_out), .flag_oe(fl_oe), .flag_pin(fl_pin));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // Period ends counted apart from the APB polling so their lag cancels out
    always @(posedge mclk) begin
        psn_q <= psn;
        if (psn_q === 1'b1 && psn === 1'b0) falls <= falls + 1;
    end

    task automatic finish_test;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1 && n < 100) begin
            @(posedge mclk);
            n++;
        end
        if (n == 100) failures++;
        d = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : apb

    // One whole switching period, fall to fall, with its on part
    task automatic meas;
        on_c  = 0;
        per_c = 0;
        repeat (3000) if (psn !== 1'b1) @(posedge mclk);
        repeat (3000) if (psn !== 1'b0) @(posedge mclk);
        while (psn === 1'b0 && per_c < 3000) begin
            @(posedge mclk);
            per_c++;
        end
        while (psn === 1'b1 && per_c < 3000) begin
            @(posedge mclk);
            per_c++;
            on_c++;
        end
    endtask : meas

    initial begin
        rstn <= 1'b0;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 8'h00;
        pwdata <= 32'h0;
        ss_near_done <= 1'b0;
        ext_en <= 1'b0;
        pin_lvl <= 1'b0;
        iout_lo <= 1'b0;
        fb_mv <= 0;
        fsi <= 12'h00a;
        repeat (16) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        apb(1'b0, bfsc_pkg::ADDR_CTRL, 32'h0);
        `CHK(d[0], bfsc_pkg::CTRL_RST)
        apb(1'b0, bfsc_pkg::ADDR_INT_MASK, 32'h0);
        `CHK(d[3:0], bfsc_pkg::INT_MASK_RST)
        apb(1'b0, 8'h10, 32'h0);
        `CHK({e, d}, 33'h100000000)
        apb(1'b0, bfsc_pkg::ADDR_STATUS, 32'h0);
        `CHK(d[2:0], bfsc_pkg::MODE_FIXED)
        meas();
        `CHK(on_c, 10)
        `CHK(per_c, (50 + 19) / 20 + 10)
        fsi <= 12'h005;
        meas();
        `CHK(on_c, 5)
        fsi <= 12'h00a;
        pin_lvl <= 1'b1;
        repeat (260) @(posedge mclk);
        apb(1'b0, bfsc_pkg::ADDR_STATUS, 32'h0);
        `CHK(d[1], 1'b0)
        repeat (800) @(posedge mclk);
        apb(1'b0, bfsc_pkg::ADDR_STATUS, 32'h0);
        `CHK(d[2:0], bfsc_pkg::MODE_SPREAD)
        prev = -1;
        k = 0;
        for (int i = 0; i < 3000 && k < 4; i++) begin
            apb(1'b0, bfsc_pkg::ADDR_STATUS, 32'h0);
            if (int'(d[12:8]) != prev) begin
                if (k > 1) `CHK(falls - f0, 32)
                prev = int'(d[12:8]);
                f0 = falls;
                k++;
                meas();
                `CHK(on_c, 10 - 10 * prev * 5 / 512)
            end
        end
        `CHK(k, 4)
        ext_en <= 1'b1;
        repeat (20) @(posedge mclk);
        apb(1'b0, bfsc_pkg::ADDR_STATUS, 32'h0);
        `CHK(d[2:0], bfsc_pkg::MODE_EXT)
        meas();
        `CHK(on_c, 20)
        ss_near_done <= 1'b1;
        meas();
        meas();
        `CHK(per_c, 8)
        ext_en <= 1'b0;
        pin_lvl <= 1'b0;
        repeat (600) @(posedge mclk);
        apb(1'b0, bfsc_pkg::ADDR_STATUS, 32'h0);
        `CHK(d[2:0], bfsc_pkg::MODE_FIXED)
        fb_mv <= -40;
        repeat (10) @(posedge mclk);
        `CHK(fl_pin, 1'b1)
        iout_lo <= 1'b1;
        repeat (10) @(posedge mclk);
        `CHK(fl_pin, 1'b0)
        iout_lo <= 1'b0;
        fb_mv <= -50;
        repeat (10) @(posedge mclk);
        `CHK(fl_pin, 1'b0)
        fb_mv <= 40;
        repeat (10) @(posedge mclk);
        `CHK({gate, psn, fl_pin}, 3'b100)
        fb_mv <= 20;
        repeat (10) @(posedge mclk);
        `CHK(gate, 1'b1)
        fb_mv <= 10;
        repeat (30) @(posedge mclk);
        `CHK({gate, fl_pin}, 2'b00)
        fb_mv <= -70;
        repeat (10) @(posedge mclk);
        `CHK(fl_pin, 1'b1)
        fb_mv <= 0;
        apb(1'b0, bfsc_pkg::ADDR_INT_STAT, 32'h0);
        `CHK(d[3:0], 4'hf)
        apb(1'b1, bfsc_pkg::ADDR_INT_MASK, 32'h0000000f);
        repeat (2) @(posedge mclk);
        ia = irq;
        apb(1'b1, bfsc_pkg::ADDR_INT_MASK, 32'h0);
        repeat (2) @(posedge mclk);
        `CHK({ia, irq}, 2'b10)
        apb(1'b1, bfsc_pkg::ADDR_INT_STAT, 32'h0000000f);
        apb(1'b0, bfsc_pkg::ADDR_INT_STAT, 32'h0);
        `CHK({irq, d[3:0]}, 5'h00)
        apb(1'b1, bfsc_pkg::ADDR_CTRL, 32'h0);
        repeat (4) @(posedge mclk);
        `CHK({gate, psn}, 2'b10)
        apb(1'b1, bfsc_pkg::ADDR_CTRL, 32'h1);
        repeat (4) @(posedge mclk);
        `CHK(gate, 1'b0)
        apb(1'b0, bfsc_pkg::ADDR_CTRL, 32'h0);
        `CHK(d[0], 1'b1)
        finish_test();
    end

    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        finish_test();
    end
endmodule : testbench

bind bfsc_top bfsc_chk chk (.mclk(mclk), .rstn(rstn), .cmp_fb_near(cmp_fb_near),
    .cmp_fb_release(cmp_fb_release), .cmp_fb_ov(cmp_fb_ov),
    .cmp_fb_ov_release(cmp_fb_ov_release), .cmp_iout_low(cmp_iout_low),
    .power_switch_node(power_switch_node), .load_disconnect_gate(load_disconnect_gate),
    .open_load_flag_out(open_load_flag_out), .open_load_flag_oe(open_load_flag_oe));
`default_nettype wire
